// ===== hw/ddr_phy_datapath.sv
// controller-facing datapath of the ddr phy: command pairs, write and read data
`timescale 1ns/1ps
module ddr_phy_datapath #(
    parameter bit data_mask_pins_option = ddr_phy_pkg::DATA_MASK_PINS_DEFAULT
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // controller address and command pairs
    input wire logic [ddr_phy_pkg::ADDR_W-1:0] ctrl_address_h,
    input wire logic [ddr_phy_pkg::ADDR_W-1:0] ctrl_address_l,
    input wire logic [ddr_phy_pkg::BANK_W-1:0] ctrl_bank_h,
    input wire logic [ddr_phy_pkg::BANK_W-1:0] ctrl_bank_l,
    input wire logic ctrl_row_strobe_n_h,
    input wire logic ctrl_row_strobe_n_l,
    input wire logic ctrl_col_strobe_n_h,
    input wire logic ctrl_col_strobe_n_l,
    input wire logic ctrl_write_strobe_n_h,
    input wire logic ctrl_write_strobe_n_l,
    input wire logic [ddr_phy_pkg::CS_W-1:0] ctrl_select_n_h,
    input wire logic [ddr_phy_pkg::CS_W-1:0] ctrl_select_n_l,
    input wire logic [ddr_phy_pkg::CS_W-1:0] ctrl_clock_enable_h,
    input wire logic [ddr_phy_pkg::CS_W-1:0] ctrl_clock_enable_l,
    input wire logic [ddr_phy_pkg::CS_W-1:0] ctrl_termination_h,
    input wire logic [ddr_phy_pkg::CS_W-1:0] ctrl_termination_l,
    // controller write side
    input wire logic [ddr_phy_pkg::WIDE_W-1:0] ctrl_write_data,
    input wire logic [ddr_phy_pkg::BE_W-1:0] ctrl_write_byte_enables,
    input wire logic ctrl_write_data_valid,
    input wire logic ctrl_strobe_burst,
    // controller read side
    input wire logic ctrl_read_capture,
    output logic [ddr_phy_pkg::WIDE_W-1:0] ctrl_read_data,
    output logic ctrl_read_data_valid,
    // pair-take strobe toward the controller
    output logic ctrl_pair_taken,
    // memory address and command pins
    output logic addr_cmd_double_rate_clock,
    output logic [ddr_phy_pkg::ADDR_W-1:0] mem_address,
    output logic [ddr_phy_pkg::BANK_W-1:0] mem_bank,
    output logic mem_row_strobe_n,
    output logic mem_col_strobe_n,
    output logic mem_write_strobe_n,
    output logic [ddr_phy_pkg::CS_W-1:0] mem_select_n,
    output logic [ddr_phy_pkg::CS_W-1:0] mem_clock_enable,
    output logic [ddr_phy_pkg::CS_W-1:0] mem_termination,
    output logic [ddr_phy_pkg::HALF_BE_W-1:0] memory_data_mask,
    // memory data and strobe pins, split into in, out and enable
    input wire logic [ddr_phy_pkg::DQ_W-1:0] mem_data_in,
    output logic [ddr_phy_pkg::DQ_W-1:0] mem_data_out,
    output logic mem_data_oe,
    output logic mem_strobe_out,
    output logic mem_strobe_oe
);
    import ddr_phy_pkg::*;

    logic phase;
    logic [CMD_W-1:0] cmd_q;
    logic [DQ_W-1:0] data_q;
    logic [DQ_W-1:0] rd_sync1;
    logic [DQ_W-1:0] rd_sync2;
    logic rd_first;
    logic rd_second;
    logic [DQ_W-1:0] rd_word0;
    logic [DQ_W-1:0] rd_word1;

    // the double-rate clock is sys_clk divided by two; each half is one sys_clk cycle
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            phase <= 1'b0;
        end else if (ce) begin
            phase <= ~phase;
        end
    end
    assign addr_cmd_double_rate_clock = phase;
    assign ctrl_pair_taken = ce & ~phase;

    ddr_pair_mux #(.WIDTH(ADDR_W), .RESET_VAL(ADDR_RESET)) u_addr (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .phase(phase),
        .data_h(ctrl_address_h), .data_l(ctrl_address_l), .q(mem_address));

    ddr_pair_mux #(.WIDTH(BANK_W), .RESET_VAL(BANK_RESET)) u_bank (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .phase(phase),
        .data_h(ctrl_bank_h), .data_l(ctrl_bank_l), .q(mem_bank));

    ddr_pair_mux #(.WIDTH(CMD_W), .RESET_VAL(CMD_IDLE)) u_cmd (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .phase(phase),
        .data_h({ctrl_row_strobe_n_h, ctrl_col_strobe_n_h, ctrl_write_strobe_n_h}),
        .data_l({ctrl_row_strobe_n_l, ctrl_col_strobe_n_l, ctrl_write_strobe_n_l}),
        .q(cmd_q));
    assign mem_row_strobe_n = cmd_q[CMD_RAS];
    assign mem_col_strobe_n = cmd_q[CMD_CAS];
    assign mem_write_strobe_n = cmd_q[CMD_WE];

    ddr_pair_mux #(.WIDTH(CS_W), .RESET_VAL(CS_IDLE)) u_select (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .phase(phase),
        .data_h(ctrl_select_n_h), .data_l(ctrl_select_n_l), .q(mem_select_n));

    ddr_pair_mux #(.WIDTH(CS_W), .RESET_VAL(RANK_OFF)) u_cke (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .phase(phase),
        .data_h(ctrl_clock_enable_h), .data_l(ctrl_clock_enable_l),
        .q(mem_clock_enable));

    ddr_pair_mux #(.WIDTH(CS_W), .RESET_VAL(RANK_OFF)) u_odt (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .phase(phase),
        .data_h(ctrl_termination_h), .data_l(ctrl_termination_l),
        .q(mem_termination));

    // low word of the wide bus goes out first, in the high half
    ddr_pair_mux #(.WIDTH(DQ_W), .RESET_VAL(DQ_RESET)) u_dq (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .phase(phase),
        .data_h(ctrl_write_data[DQ_W-1:0]), .data_l(ctrl_write_data[WIDE_W-1:DQ_W]),
        .q(data_q));
    // pins are only driven in write windows, so stale data never leaks out
    assign mem_data_out = mem_data_oe ? data_q : DQ_RESET;

    generate
        if (data_mask_pins_option) begin : g_mask
            // a mask bit is high for a byte that must not be written
            ddr_pair_mux #(.WIDTH(HALF_BE_W), .RESET_VAL(MASK_RESET)) u_mask (
                .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .phase(phase),
                .data_h(~ctrl_write_byte_enables[HALF_BE_W-1:0]),
                .data_l(~ctrl_write_byte_enables[BE_W-1:HALF_BE_W]),
                .q(memory_data_mask));
        end else begin : g_no_mask
            // the port stays for a fixed header but carries no logic
            assign memory_data_mask = MASK_RESET;
        end
    endgenerate

    // enables are taken with each pair and span both halves of it
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mem_data_oe <= 1'b0;
            mem_strobe_oe <= 1'b0;
        end else if (ce && !phase) begin
            mem_data_oe <= ctrl_write_data_valid;
            mem_strobe_oe <= ctrl_strobe_burst;
        end
    end

    // strobe toggles with the double-rate clock only inside a burst
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mem_strobe_out <= 1'b0;
        end else if (ce) begin
            mem_strobe_out <= phase ? 1'b0 : ctrl_strobe_burst;
        end
    end

    // pin data passes two flops before anything samples it
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rd_sync1 <= DQ_RESET;
            rd_sync2 <= DQ_RESET;
        end else if (ce) begin
            rd_sync1 <= mem_data_in;
            rd_sync2 <= rd_sync1;
        end
    end

    // capture: first word at the take edge, second one cycle later, then present both
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rd_first <= 1'b0;
            rd_second <= 1'b0;
            rd_word0 <= DQ_RESET;
            rd_word1 <= DQ_RESET;
        end else if (ce) begin
            rd_first <= ctrl_read_capture && !phase;
            rd_second <= rd_first;
            if (ctrl_read_capture && !phase) begin
                rd_word0 <= rd_sync2;
            end
            if (rd_first) begin
                rd_word1 <= rd_sync2;
            end
        end
    end

    // read data holds after the pulse; only the valid flag marks a fresh word
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_read_data <= RDATA_RESET;
            ctrl_read_data_valid <= 1'b0;
        end else if (ce) begin
            ctrl_read_data_valid <= rd_second;
            if (rd_second) begin
                ctrl_read_data <= {rd_word1, rd_word0};
            end
        end
    end

    a_addr_high_half: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase) |=> phase && mem_address == $past(ctrl_address_h))
        else $error("address high copy missing in high half");
    a_bank_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase) |=> mem_bank == $past(ctrl_bank_h))
        else $error("bank high copy missing");
    a_cmd_strobes: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase) |=> mem_row_strobe_n == $past(ctrl_row_strobe_n_h)
            && mem_col_strobe_n == $past(ctrl_col_strobe_n_h)
            && mem_write_strobe_n == $past(ctrl_write_strobe_n_h)
            && mem_select_n == $past(ctrl_select_n_h))
        else $error("command strobes not passed through");
    a_cke_low_half: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase) ##1 ce |=> mem_clock_enable == $past(ctrl_clock_enable_l, 2))
        else $error("clock enable low copy missing");
    a_odt_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase) |=> mem_termination == $past(ctrl_termination_h))
        else $error("termination high copy missing");
    a_mask_bytes: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase) |=> memory_data_mask == (data_mask_pins_option ?
            ~$past(ctrl_write_byte_enables[HALF_BE_W-1:0]) : MASK_RESET))
        else $error("data mask does not match byte enables");
    a_strobe_oe_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase) ##1 ce |=> mem_strobe_oe == $past(ctrl_strobe_burst, 2))
        else $error("strobe enable not held over the pair");
    a_data_oe_valid: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase) |=> mem_data_oe == $past(ctrl_write_data_valid))
        else $error("data enable does not follow write valid");
    a_pins_float: assert property (@(posedge sys_clk) disable iff (!rstn)
        !mem_data_oe |-> mem_data_out == DQ_RESET)
        else $error("pins driven without enable");
    // strobe value and its enable live in separate processes, so they can drift apart
    a_strobe_float: assert property (@(posedge sys_clk) disable iff (!rstn)
        !mem_strobe_oe |-> !mem_strobe_out)
        else $error("strobe driven without enable");
    a_read_valid: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase && ctrl_read_capture) ##1 ce ##1 ce
            |=> ctrl_read_data_valid ##1 (!ctrl_read_data_valid || !$past(ce)))
        else $error("read valid not three cycles after capture");
    a_read_word: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase && ctrl_read_capture) ##1 ce ##1 ce
            |=> ctrl_read_data[DQ_W-1:0] == $past(rd_sync2, 3))
        else $error("first read word misplaced");
endmodule : ddr_phy_datapath

// ===== hw/ddr_phy_pkg.sv
// constants shared by the controller-facing ddr phy datapath
package ddr_phy_pkg;
    localparam int ADDR_W = 13;
    localparam int BANK_W = 2;
    localparam int CS_W = 1;
    localparam int DQ_W = 8;
    localparam int RATIO = 2;
    localparam int WIDE_W = DQ_W * RATIO;
    localparam int BE_W = WIDE_W / 8;
    localparam int HALF_BE_W = DQ_W / 8;
    localparam int CMD_W = 3;
    // command field positions inside the strobe group
    localparam int CMD_RAS = 2;
    localparam int CMD_CAS = 1;
    localparam int CMD_WE = 0;
    localparam bit DATA_MASK_PINS_DEFAULT = 1'b1;
    // reset values: all strobes and selects idle high, clock enable and termination off
    localparam logic [CMD_W-1:0] CMD_IDLE = 3'h7;
    localparam logic [CS_W-1:0] CS_IDLE = {CS_W{1'b1}};
    localparam logic [CS_W-1:0] RANK_OFF = '0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = '0;
    localparam logic [BANK_W-1:0] BANK_RESET = '0;
    localparam logic [HALF_BE_W-1:0] MASK_RESET = '0;
    localparam logic [DQ_W-1:0] DQ_RESET = '0;
    localparam logic [WIDE_W-1:0] RDATA_RESET = '0;
endpackage : ddr_phy_pkg

// ===== hw/ddr_pair_mux.sv
// one half-cycle pair serializer: high copy then low copy
`timescale 1ns/1ps
module ddr_pair_mux #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and control
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic phase,
    // pair in, pin value out
    input wire logic [WIDTH-1:0] data_h,
    input wire logic [WIDTH-1:0] data_l,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] hold_l;

    // the pair is taken as phase rises, so q shows the high copy while phase is high
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            q <= RESET_VAL;
            hold_l <= RESET_VAL;
        end else if (ce) begin
            if (!phase) begin
                q <= data_h;
                hold_l <= data_l;
            end else begin
                q <= hold_l;
            end
        end
    end

    a_pair_order: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ce && !phase) ##1 ce |=> q == $past(data_l, 2))
        else $error("low copy not shown in second half");
endmodule : ddr_pair_mux

// ===== verification/ctrl_model.sv
// controller model: presents address, command and write pairs at the phy's take edges
`timescale 1ns/1ps
module ctrl_model (
    // clock and take strobe from the phy
    input wire logic sys_clk,
    input wire logic pair_taken,
    // per half: {address, bank, ras_n, cas_n, we_n, select_n, clock_enable, termination}
    output logic [20:0] pair_h,
    output logic [20:0] pair_l,
    // write and read controls
    output logic [15:0] wdata,
    output logic [1:0] be,
    output logic wvalid,
    output logic burst,
    output logic capture
);
    initial begin
        pair_h = 21'h00_003c;
        pair_l = 21'h00_003c;
        wdata = 16'h0000;
        be = 2'h0;
        wvalid = 1'b0;
        burst = 1'b0;
        capture = 1'b0;
    end

    // outside take cycles nothing we drive is meaningful, so scramble pairs and write data and clear the strobes; be alone is held
    always @(negedge sys_clk) begin
        if (pair_taken !== 1'b1) begin
            pair_h = ~pair_h;
            pair_l = ~pair_l;
            wdata = ~wdata;
            wvalid = 1'b0;
            burst = 1'b0;
            capture = 1'b0;
        end
    end

    // set up in a take cycle, hold through the take edge, return at that edge
    task automatic issue(input logic [20:0] h, input logic [20:0] l, input logic [15:0] wd,
                         input logic [1:0] en, input logic wv, input logic bu, input logic rc);
        do @(negedge sys_clk); while (pair_taken !== 1'b1);
        pair_h = h;
        pair_l = l;
        wdata = wv ? wd : ~wd;
        be = en;
        wvalid = wv;
        burst = bu;
        capture = rc;
        @(posedge sys_clk);
    endtask : issue
endmodule : ctrl_model

// ===== verification/ddr_phy_datapath_bench.sv
// self-checking bench for the controller-facing ddr phy datapath
`timescale 1ns/1ps
module ddr_phy_datapath_bench;
    import ddr_phy_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [DQ_W-1:0] mem_data_in = '0;
    logic [20:0] pair_h, pair_l;
    logic [15:0] wdata;
    logic [1:0] be;
    logic wvalid, burst, capture, taken;
    logic [WIDE_W-1:0] rdata;
    logic rvalid, dclk, ras_n, cas_n, we_n, doe, sout, soe;
    logic [ADDR_W-1:0] addr;
    logic [BANK_W-1:0] bank;
    logic [CS_W-1:0] cs_n, cke, odt;
    logic [HALF_BE_W-1:0] mask;
    logic [HALF_BE_W-1:0] mask_off;
    logic [DQ_W-1:0] dout;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [33:0] prev_l;
    logic have_prev = 1'b0;

    ctrl_model ctrl (.sys_clk(sys_clk), .pair_taken(taken), .pair_h(pair_h), .pair_l(pair_l),
        .wdata(wdata), .be(be), .wvalid(wvalid), .burst(burst), .capture(capture));

    ddr_phy_datapath DUT (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .ctrl_address_h(pair_h[20:8]), .ctrl_address_l(pair_l[20:8]),
        .ctrl_bank_h(pair_h[7:6]), .ctrl_bank_l(pair_l[7:6]),
        .ctrl_row_strobe_n_h(pair_h[5]), .ctrl_row_strobe_n_l(pair_l[5]),
        .ctrl_col_strobe_n_h(pair_h[4]), .ctrl_col_strobe_n_l(pair_l[4]),
        .ctrl_write_strobe_n_h(pair_h[3]), .ctrl_write_strobe_n_l(pair_l[3]),
        .ctrl_select_n_h(pair_h[2:2]), .ctrl_select_n_l(pair_l[2:2]),
        .ctrl_clock_enable_h(pair_h[1:1]), .ctrl_clock_enable_l(pair_l[1:1]),
        .ctrl_termination_h(pair_h[0:0]), .ctrl_termination_l(pair_l[0:0]),
        .ctrl_write_data(wdata), .ctrl_write_byte_enables(be), .ctrl_write_data_valid(wvalid),
        .ctrl_strobe_burst(burst), .ctrl_read_capture(capture), .ctrl_read_data(rdata),
        .ctrl_read_data_valid(rvalid), .ctrl_pair_taken(taken),
        .addr_cmd_double_rate_clock(dclk), .mem_address(addr), .mem_bank(bank),
        .mem_row_strobe_n(ras_n), .mem_col_strobe_n(cas_n), .mem_write_strobe_n(we_n),
        .mem_select_n(cs_n), .mem_clock_enable(cke), .mem_termination(odt),
        .memory_data_mask(mask), .mem_data_in(mem_data_in), .mem_data_out(dout),
        .mem_data_oe(doe), .mem_strobe_out(sout), .mem_strobe_oe(soe));

    // same stimulus with the mask option off: the mask port must stay at its idle level
    ddr_phy_datapath #(.data_mask_pins_option(1'b0)) DUT_no_mask (.sys_clk(sys_clk),
        .rstn(rstn), .ce(ce),
        .ctrl_address_h(pair_h[20:8]), .ctrl_address_l(pair_l[20:8]),
        .ctrl_bank_h(pair_h[7:6]), .ctrl_bank_l(pair_l[7:6]),
        .ctrl_row_strobe_n_h(pair_h[5]), .ctrl_row_strobe_n_l(pair_l[5]),
        .ctrl_col_strobe_n_h(pair_h[4]), .ctrl_col_strobe_n_l(pair_l[4]),
        .ctrl_write_strobe_n_h(pair_h[3]), .ctrl_write_strobe_n_l(pair_l[3]),
        .ctrl_select_n_h(pair_h[2:2]), .ctrl_select_n_l(pair_l[2:2]),
        .ctrl_clock_enable_h(pair_h[1:1]), .ctrl_clock_enable_l(pair_l[1:1]),
        .ctrl_termination_h(pair_h[0:0]), .ctrl_termination_l(pair_l[0:0]),
        .ctrl_write_data(wdata), .ctrl_write_byte_enables(be), .ctrl_write_data_valid(wvalid),
        .ctrl_strobe_burst(burst), .ctrl_read_capture(capture), .ctrl_read_data(),
        .ctrl_read_data_valid(), .ctrl_pair_taken(),
        .addr_cmd_double_rate_clock(), .mem_address(), .mem_bank(),
        .mem_row_strobe_n(), .mem_col_strobe_n(), .mem_write_strobe_n(),
        .mem_select_n(), .mem_clock_enable(), .mem_termination(),
        .memory_data_mask(mask_off), .mem_data_in(mem_data_in), .mem_data_out(),
        .mem_data_oe(), .mem_strobe_out(), .mem_strobe_oe());

    always #2 sys_clk = ~sys_clk;

    // memory side: read data changes every cycle so a stale or misordered word shows
    always @(negedge sys_clk) mem_data_in <= mem_data_in + 8'h01;

    function automatic logic [33:0] pins();
        return {dclk, addr, bank, ras_n, cas_n, we_n, cs_n, cke, odt, mask, dout, doe, sout, soe};
    endfunction : pins

    function automatic logic [33:0] half(input logic hi, input logic [20:0] p,
                                         input logic [7:0] d, input logic en, input logic wv,
                                         input logic bu);
        return {hi, p, ~en, wv ? d : 8'h00, wv, hi & bu, bu};
    endfunction : half

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // next pair is set up in the same cycle the previous low copy is on the pins
    task automatic pair_step(input logic [20:0] h, input logic [20:0] l, input logic [15:0] wd,
                             input logic [1:0] en, input logic wv, input logic bu);
        fork
            ctrl.issue(h, l, wd, en, wv, bu, 1'b0);
            if (have_prev) begin
                @(negedge sys_clk);
                check("low copy", pins(), prev_l);
            end
        join
        @(negedge sys_clk);
        check("high copy", pins(), half(1'b1, h, wd[7:0], en[0], wv, bu));
        check("mask option off", mask_off, 40'h0);
        prev_l = half(1'b0, l, wd[15:8], en[1], wv, bu);
        have_prev = 1'b1;
    endtask : pair_step

    task automatic command_test;
        for (int i = 0; i < 8; i++) begin
            pair_step({13'h0abc ^ 13'(i * 291), 2'(i), 6'(i * 9)},
                      {13'h1543 ^ 13'(i * 77), 2'(3 - i), 6'(63 - i * 9)},
                      16'h3c5a ^ 16'(i * 4369), 2'(i), i[1], i[2]);
        end
        @(negedge sys_clk);
        check("last low copy", pins(), prev_l);
        have_prev = 1'b0;
    endtask : command_test

    task automatic freeze_test;
        ctrl.issue(21'h15_a5a5, 21'h0a_5a5a, 16'h1234, 2'h1, 1'b1, 1'b1, 1'b0);
        @(negedge sys_clk);
        ce = 1'b0;
        repeat (3) begin
            check("frozen high copy", pins(), half(1'b1, 21'h15_a5a5, 8'h34, 1'b1, 1'b1, 1'b1));
            @(negedge sys_clk);
        end
        ce = 1'b1;
        @(negedge sys_clk);
        check("resumed low copy", pins(), half(1'b0, 21'h0a_5a5a, 8'h12, 1'b0, 1'b1, 1'b1));
    endtask : freeze_test

    task automatic read_test;
        logic [7:0] at_take;
        ctrl.issue(21'h00_003c, 21'h00_003c, 16'h0000, 2'h0, 1'b0, 1'b0, 1'b1);
        at_take = mem_data_in;
        for (int k = 1; k <= 4; k++) begin
            @(negedge sys_clk);
            check("read valid", rvalid, 40'(k == 3));
        end
        check("read data", rdata, {at_take - 8'h01, at_take - 8'h02});
    endtask : read_test

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        repeat (16) @(negedge sys_clk);
        check("reset pins", pins(), {1'b0, 13'h0000, 2'h0, 4'hf, 2'h0, 1'b0, 8'h00, 3'h0});
        check("reset read", {rdata, rvalid}, 17'h0_0000);
        rstn = 1'b1;
        command_test();
        freeze_test();
        read_test();
        read_test();
        close_out();
    end
endmodule : ddr_phy_datapath_bench
